// ---- hw/ocd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module ocd_decoder
  import ocd_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       chip_init_n_i,
  input  wire logic       cs1_n_i,
  input  wire logic       cs2_i,
  input  wire logic       cmd_or_pixel_select_i,
  input  wire logic       write_strobe_n_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  output logic            fifo_full_o,
  output logic      [3:0] page_o,
  output logic      [7:0] column_o,
  output var ocd_settings_type settings_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [13:0]      pins_s;
  logic             cs1_n_s;
  logic             cs2_s;
  logic             sel_s;
  logic             wr_n_s;
  logic             rd_n_s;
  logic             init_n_s;
  logic [7:0]       data_s;
  logic             init_s;
  logic             cs_s;

  ocd_sync #(.WIDTH(14)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({chip_init_n_i, cs1_n_i, cs2_i, cmd_or_pixel_select_i,
                 write_strobe_n_i, read_strobe_n_i, data_i}),
    .sync_o    (pins_s)
  );

  assign {init_n_s, cs1_n_s, cs2_s, sel_s, wr_n_s, rd_n_s, data_s} = pins_s;
  assign init_s = ~init_n_s;
  assign cs_s   = ~cs1_n_s & cs2_s;

  // ---------------------------------------------------------------
  // host strobes
  // ---------------------------------------------------------------
  logic             wr_low_q;
  logic             rd_low_q;
  logic             rd_low;
  logic             wr_end;
  logic             rd_start;
  logic             rd_end;
  logic             rd_sel_r;

  // write latches on the rising strobe, read starts on the falling one
  assign rd_low   = cs_s & ~rd_n_s;
  assign wr_end   = wr_low_q & wr_n_s;
  assign rd_start = rd_low & ~rd_low_q;
  assign rd_end   = ~rd_low & rd_low_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_low_q <= 1'b0;
      rd_low_q <= 1'b0;
    end else begin
      wr_low_q <= cs_s & ~wr_n_s;
      rd_low_q <= rd_low;
    end
  end

  // ---------------------------------------------------------------
  // byte queue
  // ---------------------------------------------------------------
  ocd_entry_type    push_ent;
  ocd_entry_type    ent;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  logic             take;

  assign push_ent = '{is_data: sel_s, octet: data_s};
  // ram has one read path; the decoder waits out a host read
  assign fifo_out_ready = ~rd_low & ~rd_low_q;
  assign take = fifo_out_valid & fifo_out_ready & ~init_s;

  ocd_fifo #(.WIDTH($bits(ocd_entry_type)), .DEPTH(16)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_end & ~init_s),
    .in_data_i   (push_ent),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (ent),
    .out_ready_i (fifo_out_ready)
  );

  // full flag lags one cycle; bytes written while full are dropped
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) fifo_full_o <= 1'b0;
    else       fifo_full_o <= ~fifo_in_ready;
  end

  // ---------------------------------------------------------------
  // opcode match helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] b, input logic [7:0] op,
                               input logic [7:0] mask);
    return (b & mask) == op;
  endfunction

  ocd_pend_type     pend_r;
  logic             is_cmd;
  logic             is_op;
  logic             is_data_wr;
  logic [7:0]       b;

  assign b          = ent.octet;
  assign is_cmd     = take & ~ent.is_data;
  assign is_op      = is_cmd & (pend_r == PEND_NONE);
  assign is_data_wr = take & ent.is_data;

  // second byte of a two-byte command is never decoded as opcode
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_r <= PEND_NONE;
    end else if (init_s) begin
      pend_r <= PEND_NONE;
    end else if (is_cmd) begin
      if (pend_r != PEND_NONE)                    pend_r <= PEND_NONE;
      else if (hit(b, OP_MUX, MASK_FULL))         pend_r <= PEND_MUX;
      else if (hit(b, OP_FRAME, MASK_FULL))       pend_r <= PEND_FRAME;
      else if (hit(b, OP_BRIGHT, MASK_FULL))      pend_r <= PEND_BRIGHT;
      else if (hit(b, OP_CURRENT, MASK_FULL))     pend_r <= PEND_CURRENT;
      else if (hit(b, OP_PRECHARGE, MASK_FULL))   pend_r <= PEND_PRECHARGE;
      else if (hit(b, OP_OFFSET, MASK_FULL))      pend_r <= PEND_OFFSET;
      else if (hit(b, OP_BIAS, MASK_FULL) || hit(b, OP_LOW_POWER, MASK_FULL))
        pend_r <= PEND_IGNORE;
    end
  end

  // ---------------------------------------------------------------
  // mode settings
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      settings_o <= SETTINGS_RST;
    end else if (init_s) begin
      settings_o <= SETTINGS_RST;
    end else if (is_cmd && pend_r != PEND_NONE) begin
      case (pend_r)
        PEND_MUX: begin
          settings_o.ratio_factor       <= b[5:0];
          settings_o.scanned_line_count <= {1'b0, b[5:0]} + LINES_EXTRA;
        end
        PEND_FRAME: begin
          // unlisted codes keep the old divider
          if (b[6:0] == FRAME_P4) settings_o.frame_div <= DIV_4;
          if (b[6:0] == FRAME_P6) settings_o.frame_div <= DIV_6;
          if (b[6:0] == FRAME_P8) settings_o.frame_div <= DIV_8;
        end
        PEND_BRIGHT:    settings_o.brightness   <= b;
        PEND_CURRENT:   settings_o.full_current <= b[0];
        PEND_PRECHARGE: begin
          settings_o.precharge   <= b[7:4];
          settings_o.zero_period <= b[3:0];
        end
        PEND_OFFSET:    settings_o.offset <= b[5:0];
        default: ;
      endcase
    end else if (is_op) begin
      settings_o.sleep <= 1'b0;
      if (hit(b, OP_DISP, MASK_BIT0))    settings_o.display_on   <= b[0];
      if (hit(b, OP_START, MASK_TOP2))   settings_o.start_line   <= b[5:0];
      if (hit(b, OP_COM_DIR, MASK_NIBBLE)) settings_o.com_reverse <= b[3];
      if (hit(b, OP_SEG_MAP, MASK_BIT0)) settings_o.seg_reverse  <= b[0];
      if (hit(b, OP_STATIC, MASK_BIT0)) begin
        settings_o.static_drive <= b[0];
        // power save only from the dark display
        if (b[0] && !settings_o.display_on) settings_o.sleep <= 1'b1;
      end
      if (hit(b, OP_ICON, MASK_BIT0))    settings_o.icon_on <= b[0];
      if (hit(b, OP_INVERSE, MASK_BIT0)) settings_o.inverse <= b[0];
      if (hit(b, OP_RMW, MASK_FULL))     settings_o.rmw     <= 1'b1;
      if (hit(b, OP_RMW_END, MASK_FULL)) settings_o.rmw     <= 1'b0;
      if (hit(b, OP_SOFT_RST, MASK_FULL)) begin
        settings_o.start_line  <= 6'h00;
        settings_o.rmw         <= 1'b0;
        settings_o.com_reverse <= 1'b0;
      end
      // no-op and unknown opcodes only clear sleep, like every opcode except a5 on the dark display
    end
  end

  // ---------------------------------------------------------------
  // page and column pointers
  // ---------------------------------------------------------------
  logic             addr_ok;
  logic [10:0]      ram_idx;
  logic             rd_adv;

  assign addr_ok = (page_o < RAM_PAGES) && (11'(column_o) < RAM_COLS);
  assign ram_idx = 11'(page_o) * RAM_COLS + 11'(column_o);
  assign rd_adv  = rd_end & rd_sel_r & ~settings_o.rmw;

  // column wraps at 8 bits; writes past the ram are dropped, reads there load 00
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_o   <= 4'h0;
      column_o <= 8'h00;
    end else if (init_s) begin
      page_o   <= 4'h0;
      column_o <= 8'h00;
    end else if (rd_adv) begin
      column_o <= column_o + 8'h01;
    end else if (is_data_wr) begin
      column_o <= column_o + 8'h01;
    end else if (is_op) begin
      if (hit(b, OP_PAGE, MASK_NIBBLE))   page_o <= b[3:0];
      if (hit(b, OP_COL_LO, MASK_NIBBLE)) column_o[3:0] <= b[3:0];
      if (hit(b, OP_COL_HI, MASK_NIBBLE)) column_o[7:4] <= b[3:0];
      if (hit(b, OP_SOFT_RST, MASK_FULL)) begin
        page_o   <= 4'h0;
        column_o <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // display ram and host read port
  // ---------------------------------------------------------------
  logic [7:0]       ram_r [RAM_WORDS];
  logic [7:0]       read_buf_r;
  logic [7:0]       status;

  always_ff @(posedge sys_clk_i) begin
    if (is_data_wr && addr_ok) ram_r[ram_idx] <= b;
  end

  assign status = {fifo_out_valid, ~settings_o.seg_reverse,
                   ~settings_o.display_on, init_s, 4'h0};

  // the read buffer reloads after each data read, hence the dummy read
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o     <= 8'h00;
      data_oe_o  <= 1'b0;
      rd_sel_r   <= 1'b0;
      read_buf_r <= 8'h00;
    end else if (rd_start) begin
      data_o    <= sel_s ? read_buf_r : status;
      data_oe_o <= 1'b1;
      rd_sel_r  <= sel_s;
    end else if (rd_end) begin
      data_oe_o <= 1'b0;
      if (rd_sel_r) read_buf_r <= addr_ok ? ram_r[ram_idx] : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  disp_onoff_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_op && hit(b, OP_DISP, MASK_BIT0) && !init_s |=> settings_o.display_on == $past(b[0]))
    else $error("display on/off not taken");

  start_line_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_op && hit(b, OP_START, MASK_TOP2) |=> settings_o.start_line == $past(b[5:0]))
    else $error("start line not loaded");

  page_set_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_op && hit(b, OP_PAGE, MASK_NIBBLE) && !rd_adv |=> page_o == $past(b[3:0]))
    else $error("page not loaded");

  col_high_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_op && hit(b, OP_COL_HI, MASK_NIBBLE) && !rd_adv
    |=> column_o == {$past(b[3:0]), $past(column_o[3:0])})
    else $error("column high nibble wrong");

  status_read_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_start && !sel_s |=> data_oe_o && data_o == $past(status) && data_o[3:0] == 4'h0)
    else $error("status byte wrong");

  data_adv_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_data_wr && !rd_adv |=> column_o == $past(column_o) + 8'h01)
    else $error("column did not advance");

  rmw_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_end && rd_sel_r && settings_o.rmw && !take |=> $stable(column_o))
    else $error("column moved on rmw read");

  mux_ratio_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_cmd && pend_r == PEND_MUX
    |=> settings_o.ratio_factor == $past(b[5:0])
    && settings_o.scanned_line_count == {1'b0, $past(b[5:0])} + LINES_EXTRA)
    else $error("scanned lines not factor plus two");

  bright_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_cmd && pend_r == PEND_BRIGHT |=> settings_o.brightness == $past(b))
    else $error("brightness not loaded");

  sleep_enter_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_op && b == (OP_STATIC | 8'h01) && !settings_o.display_on |=> settings_o.sleep)
    else $error("sleep not entered");

  init_dflt_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    init_s |=> !settings_o.display_on && settings_o.scanned_line_count == 7'h41
    && !settings_o.sleep && page_o == 4'h0)
    else $error("init defaults missing");

  frame_div_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_cmd && pend_r == PEND_FRAME && b[6:0] == FRAME_P4 |=> settings_o.frame_div == DIV_4)
    else $error("frame divider not four");

  rmw_exit_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_op && b == OP_RMW_END |=> !settings_o.rmw)
    else $error("read-modify-write not left");

  soft_reset_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_op && b == OP_SOFT_RST |=> page_o == 4'h0 && column_o == 8'h00
    && settings_o.start_line == 6'h00 && !settings_o.rmw && !settings_o.com_reverse)
    else $error("soft reset incomplete");

  param_skip_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_cmd && pend_r != PEND_NONE |=> pend_r == PEND_NONE && page_o == $past(page_o))
    else $error("parameter byte decoded as opcode");

endmodule // ocd_decoder
`default_nettype wire

// ---- common/ocd_pkg.sv ----
`default_nettype none
package ocd_pkg;

  // opcodes and the masks they are compared under
  localparam logic [7:0] OP_DISP      = 8'hae;
  localparam logic [7:0] OP_START     = 8'h40;
  localparam logic [7:0] OP_PAGE      = 8'hb0;
  localparam logic [7:0] OP_COL_LO    = 8'h00;
  localparam logic [7:0] OP_COL_HI    = 8'h10;
  localparam logic [7:0] OP_COM_DIR   = 8'hc0;
  localparam logic [7:0] OP_SEG_MAP   = 8'ha0;
  localparam logic [7:0] OP_STATIC    = 8'ha4;
  localparam logic [7:0] OP_INVERSE   = 8'ha6;
  localparam logic [7:0] OP_ICON      = 8'hd0;
  localparam logic [7:0] OP_RMW       = 8'he0;
  localparam logic [7:0] OP_RMW_END   = 8'hee;
  localparam logic [7:0] OP_SOFT_RST  = 8'he2;
  localparam logic [7:0] OP_MUX       = 8'ha8;
  localparam logic [7:0] OP_FRAME     = 8'haa;
  localparam logic [7:0] OP_BRIGHT    = 8'h81;
  localparam logic [7:0] OP_CURRENT   = 8'hda;
  localparam logic [7:0] OP_PRECHARGE = 8'hd9;
  localparam logic [7:0] OP_BIAS      = 8'hab;
  localparam logic [7:0] OP_OFFSET    = 8'ha3;
  localparam logic [7:0] OP_LOW_POWER = 8'hd8;
  localparam logic [7:0] MASK_FULL    = 8'hff;
  localparam logic [7:0] MASK_BIT0    = 8'hfe;
  localparam logic [7:0] MASK_TOP2    = 8'hc0;
  localparam logic [7:0] MASK_NIBBLE  = 8'hf0;

  // frame parameter codes and the divisors they pick
  localparam logic [6:0] FRAME_P4 = 7'h41;
  localparam logic [6:0] FRAME_P6 = 7'h42;
  localparam logic [6:0] FRAME_P8 = 7'h43;
  localparam logic [3:0] DIV_4    = 4'h4;
  localparam logic [3:0] DIV_6    = 4'h6;
  localparam logic [3:0] DIV_8    = 4'h8;
  localparam logic [6:0] LINES_EXTRA = 7'h02;

  // status byte bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_DIR  = 6;
  localparam int ST_OFF  = 5;
  localparam int ST_INIT = 4;

  // display ram geometry
  localparam logic [3:0]  RAM_PAGES = 4'h9;
  localparam logic [10:0] RAM_COLS  = 11'h084;
  localparam int          RAM_WORDS = 1188;

  typedef struct packed {
    logic       display_on;
    logic [5:0] start_line;
    logic [5:0] ratio_factor;
    logic [6:0] scanned_line_count;
    logic [3:0] frame_div;
    logic       com_reverse;
    logic       seg_reverse;
    logic       static_drive;
    logic [7:0] brightness;
    logic       icon_on;
    logic       inverse;
    logic       full_current;
    logic [3:0] precharge;
    logic [3:0] zero_period;
    logic [5:0] offset;
    logic       rmw;
    logic       sleep;
  } ocd_settings_type;

  localparam ocd_settings_type SETTINGS_RST = '{
    display_on: 1'h0, start_line: 6'h00, ratio_factor: 6'h3f,
    scanned_line_count: 7'h41, frame_div: 4'h6, com_reverse: 1'h0,
    seg_reverse: 1'h0, static_drive: 1'h0, brightness: 8'h80,
    icon_on: 1'h0, inverse: 1'h0, full_current: 1'h0, precharge: 4'h8,
    zero_period: 4'h8, offset: 6'h00, rmw: 1'h0, sleep: 1'h0};

  typedef struct packed {
    logic       is_data;
    logic [7:0] octet;
  } ocd_entry_type;

  typedef enum logic [2:0] {
    PEND_NONE, PEND_MUX, PEND_FRAME, PEND_BRIGHT,
    PEND_CURRENT, PEND_PRECHARGE, PEND_OFFSET, PEND_IGNORE
  } ocd_pend_type;

endpackage
`default_nettype wire

// ---- hw/ocd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; first stage feeds only the second
module ocd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // ocd_sync
`default_nettype wire

// ---- hw/ocd_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
// byte queue between the host port and the decoder
module ocd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage has no reset; only the pointers and the count need one
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // ocd_fifo
`default_nettype wire

// ---- tb/ocd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ocd_host (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] dev_d_i,
  input  wire logic       dev_oe_i,
  output logic            cs1_n_o,
  output logic            cs2_o,
  output logic            sel_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic      [7:0] d_o
);
  logic [7:0] hd;
  logic       hoe;
  // ------------------------------------------------
  // bus level
  // ------------------------------------------------
  // released bus shows the inverse of the last host byte, no pull
  assign d_o = hoe ? hd : (dev_oe_i ? dev_d_i : ~hd);
  // chip kept selected so a stalled read can overlap writes
  initial begin
    cs1_n_o = 1'b0;
    cs2_o = 1'b1;
    sel_o = 1'b0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    hd = 8'h00;
    hoe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // write strobe held 4 cycles each way, read strobe 5 low and 4 high, all above the 3-cycle minimum
  task automatic wr(input logic sel, input logic [7:0] b);
    sel_o = sel;
    hd = b;
    hoe = 1'b1;
    wr_n_o = 1'b0;
    hold(4);
    wr_n_o = 1'b1;
    // let go a cycle early, so a following write never flips it twice at once
    hold(3);
    hoe = 1'b0;
    hold(1);
  endtask
  task automatic rd(input logic sel, output logic [7:0] b);
    sel_o = sel;
    rd_n_o = 1'b0;
    hold(5);
    b = dev_d_i;
    rd_n_o = 1'b1;
    hold(4);
  endtask
  // status read left open, so the queue cannot drain
  task automatic stall(input logic on);
    sel_o = 1'b0;
    rd_n_o = ~on;
    hold(4);
  endtask
endmodule // ocd_host
`default_nettype wire

// ---- tb/oled_command_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module oled_command_decoder_tb;
  import ocd_pkg::*;
  logic             sys_clk_i, rst_i, init_n, cs1_n, cs2, sel, wr_n, rd_n, oe, full;
  logic [7:0]       bus, dout, col, mcol, s, b, d, c;
  logic [3:0]       page, mpage, pg;
  logic [31:0]      r;
  ocd_settings_type st, exp;
  int               err_count, tests_run;
  ocd_host i_host (.sys_clk_i(sys_clk_i), .dev_d_i(dout), .dev_oe_i(oe), .cs1_n_o(cs1_n),
    .cs2_o(cs2), .sel_o(sel), .wr_n_o(wr_n), .rd_n_o(rd_n), .d_o(bus));
  ocd_decoder i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .chip_init_n_i(init_n),
    .cs1_n_i(cs1_n), .cs2_i(cs2), .cmd_or_pixel_select_i(sel), .write_strobe_n_i(wr_n),
    .read_strobe_n_i(rd_n), .data_i(bus), .data_o(dout), .data_oe_o(oe),
    .fifo_full_o(full), .page_o(page), .column_o(col), .settings_o(st));
  // ------------------------------------------------
  // checking helpers
  // ------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic results;
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [7:0] stat(input ocd_settings_type e, input logic ini);
    return {1'b0, ~e.seg_reverse, ~e.display_on, ini, 4'h0};
  endfunction
  // whole struct compared, so stray side effects show too
  task automatic chk;
    check(st, exp);
    check(page, mpage);
    check(col, mcol);
  endtask
  // bounded poll of busy; a hang ends the run
  task automatic settle;
    for (int i = 0; i < 8; i++) begin
      i_host.rd(1'b0, s);
      if (s[7] === 1'b0) return;
    end
    err_count++;
    results();
  endtask
  task automatic cmd(input logic [7:0] v);
    i_host.wr(1'b0, v);
    settle();
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    rst_i = 1'b1;
    init_n = 1'b1;
    err_count = 0;
    tests_run = 0;
    exp = SETTINGS_RST;
    mcol = 8'h00;
    mpage = 4'h0;
    void'($urandom(32'h77a4c62b));
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk();
    i_host.rd(1'b0, s);
    check(s, stat(exp, 1'b0));
    cmd(8'haf);
    exp.display_on = 1'b1;
    chk();
    check(s, stat(exp, 1'b0));
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      pg = 4'(r[3:0] % 9);
      c = 8'(r[15:8] % 132);
      d = r[23:16];
      cmd(8'h40 | {2'b00, r[5:0]});
      exp.start_line = r[5:0];
      cmd(8'hb0 | {4'h0, pg});
      cmd(8'h10 | {4'h0, c[7:4]});
      cmd(8'h00 | {4'h0, c[3:0]});
      mpage = pg;
      mcol = c;
      chk();
      // data byte between opcode and parameter
      cmd(8'h81);
      i_host.wr(1'b1, d);
      settle();
      mcol = mcol + 8'h01;
      cmd(r[31:24]);
      exp.brightness = r[31:24];
      chk();
      cmd(8'h10 | {4'h0, c[7:4]});
      cmd(8'h00 | {4'h0, c[3:0]});
      i_host.rd(1'b1, b);
      i_host.rd(1'b1, b);
      mcol = c + 8'h02;
      check(b, d);
      cmd(8'ha8);
      cmd(r[23:16]);
      cmd(8'hd9);
      cmd(r[31:24]);
      cmd(8'ha3);
      cmd(r[15:8]);
      cmd(8'hda);
      cmd(r[23:16]);
      exp.ratio_factor = r[21:16];
      exp.scanned_line_count = {1'b0, r[21:16]} + 7'h02;
      exp.precharge = r[31:28];
      exp.zero_period = r[27:24];
      exp.offset = r[13:8];
      exp.full_current = r[16];
      chk();
    end
    for (int k = 0; k < 3; k++) begin
      cmd(8'haa);
      cmd(8'(8'h41 + k));
      exp.frame_div = 4'(4 + 2 * k);
      chk();
    end
    for (int k = 0; k < 2; k++) begin
      cmd(8'hc0 | 8'(k * 8));
      cmd(8'ha0 | 8'(k));
      cmd(8'hd0 | 8'(k));
      cmd(8'ha6 | 8'(k));
      cmd(8'ha4 | 8'(k));
      exp.com_reverse = k[0];
      exp.seg_reverse = k[0];
      exp.icon_on = k[0];
      exp.inverse = k[0];
      exp.static_drive = k[0];
      chk();
      check(s, stat(exp, 1'b0));
    end
    cmd(8'ha4);
    cmd(8'he0);
    i_host.rd(1'b1, b);
    exp.static_drive = 1'b0;
    exp.rmw = 1'b1;
    chk();
    i_host.wr(1'b1, r[7:0]);
    settle();
    mcol = mcol + 8'h01;
    chk();
    cmd(8'hee);
    i_host.rd(1'b1, b);
    mcol = mcol + 8'h01;
    exp.rmw = 1'b0;
    chk();
    cmd(8'he0);
    cmd(8'he2);
    exp.start_line = 6'h00;
    exp.com_reverse = 1'b0;
    mcol = 8'h00;
    mpage = 4'h0;
    chk();
    cmd(8'hae);
    cmd(8'ha5);
    exp.display_on = 1'b0;
    exp.static_drive = 1'b1;
    exp.sleep = 1'b1;
    chk();
    cmd(8'he3);
    cmd(8'hf7);
    exp.sleep = 1'b0;
    chk();
    // parameters of the unused two-byte commands look like start-line opcodes
    cmd(8'hab);
    cmd(8'h48);
    cmd(8'hd8);
    cmd(8'h4a);
    chk();
    // eighteen writes into a queue held by an open read
    i_host.stall(1'b1);
    check(oe, 1'b1);
    check(dout, stat(exp, 1'b0));
    for (int k = 0; k < 18; k++) i_host.wr(1'b0, 8'(k));
    check(full, 1'b1);
    i_host.stall(1'b0);
    settle();
    mcol = 8'h0f;
    chk();
    check(full, 1'b0);
    init_n = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    i_host.rd(1'b0, s);
    exp = SETTINGS_RST;
    mcol = 8'h00;
    chk();
    check(s, stat(exp, 1'b1));
    init_n = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    results();
  end
endmodule // oled_command_decoder_tb
`default_nettype wire
